// ===== rtl/isgc_pkg.sv
// Constants and types of the two-wire slave port
// Assumes: used by the slave module through scoped names
package isgc_pkg;

  // ----------------------------------------
  // Bit counting of synchronised bus clock edges on the core clock
  // ----------------------------------------
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] BITS_DATA = 4'h8;
  localparam logic [3:0] BITS_ACK = 4'h9;

  // ----------------------------------------
  // Fixed addresses and reset values
  // ----------------------------------------
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [4:0] TEN_HI_PREFIX = 5'h1E;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [1:0] SYNC_RST = 2'h3;

  // ----------------------------------------
  // Slave sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_LO,
    ST_RX,
    ST_TX
  } isgc_state_t;

endpackage : isgc_pkg

// ===== rtl/isgc_slave.sv
// Two-wire bus slave: address match, receive, transmit, general call
// Assumes: open-drain pins resolved outside; software pulses are one cycle
`timescale 1ns/1ps
`default_nettype none

module isgc_slave (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic SCL_CLK,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SCL_OUT,
  output logic SCL_OE_N,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  input wire logic PORT_ENABLE,
  input wire logic TEN_BIT_MODE,
  input wire logic BROADCAST_ENABLE,
  input wire logic [7:0] OWN_ADDRESS,
  input wire logic OWN_ADDRESS_WR,
  input wire logic BUFFER_RD,
  input wire logic BUFFER_WR,
  input wire logic [7:0] BUFFER_WDATA,
  input wire logic CLOCK_RELEASE_SET,
  input wire logic EVENT_CLR,
  input wire logic OVERFLOW_CLR,
  output logic [7:0] RX_TX_BUFFER,
  output logic BUFFER_FULL_FLAG,
  output logic RECEIVE_OVERFLOW_FLAG,
  output logic PORT_EVENT_FLAG,
  output logic READ_DIRECTION,
  output logic ADDRESS_UPDATE_FLAG,
  output logic CLOCK_RELEASE_BIT
);

  // ----------------------------------------
  // Link domain: receive shifter
  // ----------------------------------------
  logic [7:0] link_sreg_r;

  always_ff @(posedge SCL_CLK) begin
    link_sreg_r <= {link_sreg_r[6:0], SDA_IN};
  end

  // ----------------------------------------
  // Pin synchronisers and bus events
  // ----------------------------------------
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic scl_d_r;
  logic sda_d_r;

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      scl_sync_r <= isgc_pkg::SYNC_RST;
      sda_sync_r <= isgc_pkg::SYNC_RST;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], SCL_IN};
      sda_sync_r <= {sda_sync_r[0], SDA_IN};
      scl_d_r <= scl_sync_r[1];
      sda_d_r <= sda_sync_r[1];
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise = scl_sync_r[1] && !scl_d_r;
  assign scl_fall = !scl_sync_r[1] && scl_d_r;
  assign start_det = scl_sync_r[1] && scl_d_r && sda_d_r && !sda_sync_r[1];
  assign stop_det = scl_sync_r[1] && scl_d_r && !sda_d_r && sda_sync_r[1];

  // ----------------------------------------
  // Bit counter and byte phases
  // ----------------------------------------
  isgc_pkg::isgc_state_t state_r;
  isgc_pkg::isgc_state_t state_nxt;
  logic [3:0] bit_cnt_r;
  logic byte_end;
  logic ack_end;
  logic ack_rise;
  assign byte_end = scl_fall && (bit_cnt_r == isgc_pkg::BITS_DATA);
  assign ack_end = scl_fall && (bit_cnt_r == isgc_pkg::BITS_ACK);
  assign ack_rise = scl_rise && (bit_cnt_r == isgc_pkg::BITS_DATA);

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N || start_det || ack_end) begin
      bit_cnt_r <= isgc_pkg::CNT_RST;
    end else if (scl_rise && bit_cnt_r < isgc_pkg::BITS_ACK) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  // ----------------------------------------
  // Byte decision at the eighth falling edge
  // ----------------------------------------
  logic bf_r;
  logic ov_r;
  logic ua_r;
  logic hold_r;
  logic nack_r;
  logic ovf_cond;
  logic gc_hit;
  logic hi_hit;
  logic lo_hit;
  logic load_nxt;
  logic ack_nxt;
  logic ua_set;
  logic arm_nxt;
  logic stretch;
  logic release_clk;
  assign ovf_cond = bf_r || ov_r;
  assign gc_hit = BROADCAST_ENABLE && (link_sreg_r == isgc_pkg::GC_ADDR);
  assign hi_hit = (link_sreg_r[7:1] == OWN_ADDRESS[7:1])
    && (!TEN_BIT_MODE || link_sreg_r[7:3] == isgc_pkg::TEN_HI_PREFIX);
  assign lo_hit = link_sreg_r == OWN_ADDRESS;
  assign stretch = (state_r == isgc_pkg::ST_TX && !nack_r) || ua_r;
  assign release_clk = CLOCK_RELEASE_SET || (OWN_ADDRESS_WR && ua_r);

  always_comb begin
    state_nxt = state_r;
    load_nxt = 1'b0;
    ack_nxt = 1'b0;
    ua_set = 1'b0;
    arm_nxt = 1'b0;
    if (byte_end) begin
      case (state_r)
        isgc_pkg::ST_ADDR: begin
          arm_nxt = gc_hit || hi_hit;
          if (ovf_cond) begin
            state_nxt = isgc_pkg::ST_IDLE;
          end else if (gc_hit) begin
            load_nxt = 1'b1;
            ack_nxt = 1'b1;
            state_nxt = isgc_pkg::ST_RX;
          end else if (hi_hit) begin
            load_nxt = 1'b1;
            ack_nxt = 1'b1;
            if (link_sreg_r[0]) begin
              state_nxt = isgc_pkg::ST_TX;
            end else if (TEN_BIT_MODE) begin
              ua_set = 1'b1;
              state_nxt = isgc_pkg::ST_ADDR_LO;
            end else begin
              state_nxt = isgc_pkg::ST_RX;
            end
          end else begin
            state_nxt = isgc_pkg::ST_IDLE;
          end
        end
        isgc_pkg::ST_ADDR_LO: begin
          arm_nxt = lo_hit;
          if (lo_hit && !ovf_cond) begin
            load_nxt = 1'b1;
            ack_nxt = 1'b1;
            ua_set = 1'b1;
            state_nxt = isgc_pkg::ST_RX;
          end else begin
            state_nxt = isgc_pkg::ST_IDLE;
          end
        end
        isgc_pkg::ST_RX: begin
          arm_nxt = 1'b1;
          load_nxt = !bf_r;
          ack_nxt = !ovf_cond;
        end
        isgc_pkg::ST_TX: begin
          arm_nxt = 1'b1;
        end
        default: begin
          arm_nxt = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N || !PORT_ENABLE || stop_det) begin
      state_r <= isgc_pkg::ST_IDLE;
    end else if (start_det) begin
      state_r <= isgc_pkg::ST_ADDR;
    end else if (ack_end && state_r == isgc_pkg::ST_TX && nack_r) begin
      state_r <= isgc_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Buffer, full and overflow flags
  // ----------------------------------------
  logic [7:0] tx_shift_r;

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      RX_TX_BUFFER <= isgc_pkg::BYTE_RST;
    end else if (load_nxt) begin
      RX_TX_BUFFER <= link_sreg_r;
    end else if (BUFFER_WR) begin
      RX_TX_BUFFER <= BUFFER_WDATA;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      bf_r <= 1'b0;
    end else if (load_nxt) begin
      bf_r <= 1'b1;
    end else if (BUFFER_RD) begin
      bf_r <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      ov_r <= 1'b0;
    end else if (byte_end && state_r == isgc_pkg::ST_RX && bf_r) begin
      ov_r <= 1'b1;
    end else if (OVERFLOW_CLR) begin
      ov_r <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      READ_DIRECTION <= 1'b0;
    end else if (load_nxt && state_r != isgc_pkg::ST_RX) begin
      READ_DIRECTION <= (state_nxt == isgc_pkg::ST_TX);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N || start_det) begin
      ua_r <= 1'b0;
    end else if (ua_set) begin
      ua_r <= 1'b1;
    end else if (OWN_ADDRESS_WR) begin
      ua_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Port event flag
  // ----------------------------------------
  logic evt_arm_r;

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N || start_det || ack_end) begin
      evt_arm_r <= 1'b0;
    end else if (byte_end) begin
      evt_arm_r <= arm_nxt;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      PORT_EVENT_FLAG <= 1'b0;
    end else if (ack_end && evt_arm_r) begin
      PORT_EVENT_FLAG <= 1'b1;
    end else if (EVENT_CLR) begin
      PORT_EVENT_FLAG <= 1'b0;
    end
  end

  // ----------------------------------------
  // Transmit path and clock stretching
  // ----------------------------------------
  // Write loads shifter
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      tx_shift_r <= isgc_pkg::BYTE_RST;
    end else if (BUFFER_WR) begin
      tx_shift_r <= BUFFER_WDATA;
    end else if (scl_fall && state_r == isgc_pkg::ST_TX && bit_cnt_r != isgc_pkg::CNT_RST
        && bit_cnt_r < isgc_pkg::BITS_DATA) begin
      tx_shift_r <= {tx_shift_r[6:0], 1'b0};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N || start_det) begin
      nack_r <= 1'b0;
    end else if (ack_rise && state_r == isgc_pkg::ST_TX) begin
      nack_r <= link_sreg_r[0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N || !PORT_ENABLE || start_det || stop_det) begin
      hold_r <= 1'b0;
    end else if (ack_end && stretch) begin
      hold_r <= 1'b1;
    end else if (release_clk) begin
      hold_r <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      CLOCK_RELEASE_BIT <= 1'b0;
    end else if (ack_end && stretch) begin
      CLOCK_RELEASE_BIT <= 1'b0;
    end else if (release_clk) begin
      CLOCK_RELEASE_BIT <= 1'b1;
    end
  end

  // ----------------------------------------
  // Open-drain drivers
  // ----------------------------------------
  logic ack_drv_r;
  logic sda_low_nxt;

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N || !PORT_ENABLE || start_det || ack_end) begin
      ack_drv_r <= 1'b0;
    end else if (byte_end) begin
      ack_drv_r <= ack_nxt;
    end
  end

  // Bit held through eighth high
  // Set up while stretched, released after eighth fall
  assign sda_low_nxt = ack_drv_r || (state_r == isgc_pkg::ST_TX && !evt_arm_r
    && bit_cnt_r <= isgc_pkg::BITS_DATA && !tx_shift_r[7]);

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      SDA_OE_N <= 1'b1;
      SCL_OE_N <= 1'b1;
    end else begin
      SDA_OE_N <= !sda_low_nxt;
      SCL_OE_N <= !hold_r;
    end
  end

  assign SDA_OUT = 1'b0;
  assign SCL_OUT = 1'b0;
  assign BUFFER_FULL_FLAG = bf_r;
  assign RECEIVE_OVERFLOW_FLAG = ov_r;
  assign ADDRESS_UPDATE_FLAG = ua_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  // Ack only with both flags clear
  a_rx_ack_gate: assert property ((byte_end && state_r == isgc_pkg::ST_RX) |=>
    (ack_drv_r == $past(!bf_r && !ov_r))) else $error("rx ack gate wrong");
  a_ovf_load_nack: assert property ((byte_end && state_r == isgc_pkg::ST_RX && ov_r && !bf_r)
    |=> (RX_TX_BUFFER == $past(link_sreg_r)) && !ack_drv_r) else $error("overflow load wrong");
  a_addr_ovf_nack: assert property ((byte_end && state_r == isgc_pkg::ST_ADDR && ovf_cond)
    |=> !ack_drv_r ##1 !ack_drv_r) else $error("address acked on overflow");
  a_event_ninth: assert property ((ack_end && evt_arm_r) |=> PORT_EVENT_FLAG)
    else $error("event flag not set");
  a_event_sticky: assert property ((PORT_EVENT_FLAG && !EVENT_CLR) |=> PORT_EVENT_FLAG)
    else $error("event flag dropped");
  a_read_match: assert property ((byte_end && state_r == isgc_pkg::ST_ADDR && hi_hit
    && !gc_hit && !ovf_cond && link_sreg_r[0]) |=> READ_DIRECTION && bf_r
    && state_r == isgc_pkg::ST_TX) else $error("read match wrong");
  a_stretch_hold: assert property ((ack_end && state_r == isgc_pkg::ST_TX && !nack_r)
    |=> hold_r && !CLOCK_RELEASE_BIT) else $error("no stretch after ack");
  a_nack_idle: assert property ((ack_end && state_r == isgc_pkg::ST_TX && nack_r
    && !start_det && !stop_det) |=> state_r == isgc_pkg::ST_IDLE) else $error("nack not ended");
  a_gc_no_ua: assert property ((byte_end && state_r == isgc_pkg::ST_ADDR && gc_hit
    && !ovf_cond) |=> state_r == isgc_pkg::ST_RX && !ua_r) else $error("general call wrong");
  a_start_restart: assert property ((start_det && PORT_ENABLE) |=>
    state_r == isgc_pkg::ST_ADDR && bit_cnt_r == isgc_pkg::CNT_RST) else $error("start ignored");

  c_general_call: cover property (byte_end && state_r == isgc_pkg::ST_ADDR && gc_hit);
  c_tx_nack: cover property (ack_end && state_r == isgc_pkg::ST_TX && nack_r);
  c_ten_bit: cover property (ua_set && state_r == isgc_pkg::ST_ADDR_LO);
  c_rx_overflow: cover property (byte_end && state_r == isgc_pkg::ST_RX && bf_r);

endmodule : isgc_slave

`default_nettype wire

// ===== sim/isgc_bus_master.sv
// Behavioural bus master for the two-wire slave port
// Assumes: wires resolved by the bench with pull-ups; tasks called from the bench
`timescale 1ns/1ps
`default_nettype none

module isgc_bus_master (
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe_n,
  output logic sda_oe_n,
  output logic hung
);
  localparam int HALF = 120;

  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
    hung = 1'b0;
  end

  // ----------------------------------------
  // Clock pulses
  // ----------------------------------------
  // check clock line
  task automatic rise();
    int n;
    n = 0;
    scl_oe_n = 1'b1;
    while (scl !== 1'b1 && n < 4000) begin
      #12;
      n++;
    end
    if (n >= 4000) hung = 1'b1;
    #HALF;
  endtask : rise

  task automatic bit_io(input logic b, output logic s);
    sda_oe_n = b;
    #HALF;
    rise();
    s = sda;
    scl_oe_n = 1'b0;
  endtask : bit_io

  // ----------------------------------------
  // Frames
  // ----------------------------------------
  task automatic start();
    sda_oe_n = 1'b1;
    #HALF;
    rise();
    sda_oe_n = 1'b0;
    #HALF;
    scl_oe_n = 1'b0;
  endtask : start

  task automatic stop();
    sda_oe_n = 1'b0;
    #HALF;
    rise();
    sda_oe_n = 1'b1;
    #HALF;
  endtask : stop

  task automatic xbyte(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack_n);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(mack, ack_n);
  endtask : xbyte
endmodule : isgc_bus_master
`default_nettype wire

// ===== sim/isgc_slave_tb_top.sv
// Self-checking bench of the two-wire slave port
// Assumes: design and bus master model compiled before this file
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
  $display("BAD %0t got %h want %h", $time, a, e); end end

module isgc_slave_tb_top;
  typedef struct packed {logic [7:0] d; logic ack_n; logic [7:0] rb; logic bf; logic ov; logic ev;} isgc_exp_t;
  logic core_clk, rst_n, en, ten, bce, oaw, rd, wr, rel, evc, ovc, ackv, junk;
  logic [7:0] own, wdata, rxv, d, lb, hb;
  logic [6:0] a7;
  logic [7:0] rx_tx_buffer;
  logic bf_flag, ov_flag, ev_flag, rd_dir, ua_flag, rel_bit, scl_out, sda_out, d_scl_oe_n, d_sda_oe_n;
  logic m_scl_oe_n, m_sda_oe_n, m_hung;
  wire scl;
  wire sda;
  int errors = 0;
  int tests_run = 0;
  isgc_exp_t q[$];
  isgc_exp_t e;
  event got;

  assign scl = m_scl_oe_n & d_scl_oe_n;
  assign sda = m_sda_oe_n & d_sda_oe_n;

  isgc_slave u_isgc_slave (.CORE_CLK(core_clk), .RESET_N(rst_n), .SCL_CLK(scl), .SCL_IN(scl), .SDA_IN(sda),
    .SCL_OUT(scl_out), .SCL_OE_N(d_scl_oe_n), .SDA_OUT(sda_out), .SDA_OE_N(d_sda_oe_n), .PORT_ENABLE(en),
    .TEN_BIT_MODE(ten), .BROADCAST_ENABLE(bce), .OWN_ADDRESS(own), .OWN_ADDRESS_WR(oaw), .BUFFER_RD(rd),
    .BUFFER_WR(wr), .BUFFER_WDATA(wdata), .CLOCK_RELEASE_SET(rel), .EVENT_CLR(evc), .OVERFLOW_CLR(ovc),
    .RX_TX_BUFFER(rx_tx_buffer), .BUFFER_FULL_FLAG(bf_flag), .RECEIVE_OVERFLOW_FLAG(ov_flag),
    .PORT_EVENT_FLAG(ev_flag), .READ_DIRECTION(rd_dir), .ADDRESS_UPDATE_FLAG(ua_flag), .CLOCK_RELEASE_BIT(rel_bit));

  isgc_bus_master u_isgc_bus_master (.scl(scl), .sda(sda), .scl_oe_n(m_scl_oe_n), .sda_oe_n(m_sda_oe_n),
    .hung(m_hung));

  // ----------------------------------------
  // Clock, watchdog, result watcher
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    #700000;
    errors++;
    end_sim();
  end

  always @(got) begin
    e = q.pop_front();
    `CHK(rxv, e.d)
    `CHK(ackv, e.ack_n)
    `CHK(rx_tx_buffer, e.rb)
    `CHK(bf_flag, e.bf)
    `CHK(ov_flag, e.ov)
    `CHK(ev_flag, e.ev)
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  function automatic isgc_exp_t mk(logic [7:0] dd, logic a, logic [7:0] b, logic f, logic o, logic v);
    mk = {dd, a, b, f, o, v};
  endfunction : mk

  // Mask order: own address write, overflow clr, event clr, release, write, read
  task automatic sw(input logic [5:0] m);
    @(negedge core_clk);
    {oaw, ovc, evc, rel, wr, rd} = m;
    @(negedge core_clk);
    {oaw, ovc, evc, rel, wr, rd} = 6'h00;
  endtask : sw

  task automatic xfer(input logic [7:0] tx, input logic mack, input isgc_exp_t ex);
    q.push_back(ex);
    u_isgc_bus_master.xbyte(tx, mack, rxv, ackv);
    if (m_hung) begin
      errors++;
      end_sim();
    end
    repeat (8) @(negedge core_clk);
    -> got;
    @(negedge core_clk);
    sw(6'h08);
  endtask : xfer

  task automatic stretch();
    int n;
    for (n = 0; n < 200 && d_scl_oe_n !== 1'b0; n++) @(negedge core_clk);
    `CHK(d_scl_oe_n, 1'b0)
    if (n >= 200) begin
      end_sim();
    end
  endtask : stretch

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0; en = 1'b1; ten = 1'b0; bce = 1'b0; wdata = 8'h00;
    {oaw, ovc, evc, rel, wr, rd} = 6'h00;
    void'($urandom(32'hF2D5));
    a7 = 7'h01 + 7'($urandom % 119);
    own = {a7, 1'b0};
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    `CHK({rx_tx_buffer, bf_flag, ov_flag, ev_flag, ua_flag, d_scl_oe_n, d_sda_oe_n}, 14'h0003)
    // Receive with full and overflow cases
    d = 8'($urandom);
    u_isgc_bus_master.start();
    xfer(own, 1'b1, mk(own, 1'b0, own, 1'b1, 1'b0, 1'b1));
    `CHK(rd_dir, 1'b0)
    sw(6'h01);
    xfer(d, 1'b1, mk(d, 1'b0, d, 1'b1, 1'b0, 1'b1));
    xfer(~d, 1'b1, mk(~d, 1'b1, d, 1'b1, 1'b1, 1'b1));
    sw(6'h01);
    xfer(d ^ 8'h5A, 1'b1, mk(d ^ 8'h5A, 1'b1, d ^ 8'h5A, 1'b1, 1'b1, 1'b1));
    sw(6'h11);
    u_isgc_bus_master.stop();
    $display("test receive done");
    // Restart mid-address, busy address, foreign address
    u_isgc_bus_master.start();
    repeat (3) u_isgc_bus_master.bit_io(1'b0, junk);
    u_isgc_bus_master.start();
    xfer(own, 1'b1, mk(own, 1'b0, own, 1'b1, 1'b0, 1'b1));
    u_isgc_bus_master.start();
    xfer(own, 1'b1, mk(own, 1'b1, own, 1'b1, 1'b0, 1'b1));
    sw(6'h01);
    u_isgc_bus_master.start();
    xfer({a7 ^ 7'h01, 1'b0}, 1'b1, mk({a7 ^ 7'h01, 1'b0}, 1'b1, own, 1'b0, 1'b0, 1'b0));
    u_isgc_bus_master.stop();
    $display("test addressing done");
    // General call in both address modes
    lb = own;
    for (int m = 0; m < 2; m++) begin
      ten = m[0];
      bce = 1'b0;
      u_isgc_bus_master.start();
      xfer(8'h00, 1'b1, mk(8'h00, 1'b1, lb, 1'b0, 1'b0, 1'b0));
      bce = 1'b1;
      u_isgc_bus_master.start();
      xfer(8'h00, 1'b1, mk(8'h00, 1'b0, 8'h00, 1'b1, 1'b0, 1'b1));
      `CHK(ua_flag, 1'b0)
      sw(6'h01);
      d = 8'($urandom);
      xfer(d, 1'b1, mk(d, 1'b0, d, 1'b1, 1'b0, 1'b1));
      sw(6'h01);
      lb = d;
      u_isgc_bus_master.stop();
    end
    $display("test general call done");
    // Transmit: master acks first byte, refuses second
    ten = 1'b0;
    u_isgc_bus_master.start();
    xfer({a7, 1'b1}, 1'b1, mk({a7, 1'b1}, 1'b0, {a7, 1'b1}, 1'b1, 1'b0, 1'b1));
    `CHK(rd_dir, 1'b1)
    sw(6'h01);
    for (int i = 0; i < 2; i++) begin
      d = 8'($urandom);
      fork
        xfer(8'hFF, i[0], mk(d, i[0], d, 1'b0, 1'b0, 1'b1));
        begin
          stretch();
          wdata = d;
          sw(6'h02);
          sw(6'h04);
          `CHK(rel_bit, 1'b1)
        end
      join
    end
    `CHK({d_scl_oe_n, d_sda_oe_n}, 2'h3)
    u_isgc_bus_master.stop();
    $display("test transmit done");
    // Ten-bit high byte then address reload
    ten = 1'b1;
    hb = {5'h1E, 2'($urandom), 1'b0};
    own = hb;
    u_isgc_bus_master.start();
    xfer(hb, 1'b1, mk(hb, 1'b0, hb, 1'b1, 1'b0, 1'b1));
    `CHK(ua_flag, 1'b1)
    own = 8'($urandom);
    sw(6'h21);
    `CHK(ua_flag, 1'b0)
    xfer(own, 1'b1, mk(own, 1'b0, own, 1'b1, 1'b0, 1'b1));
    `CHK(ua_flag, 1'b1)
    own = hb;
    sw(6'h21);
    `CHK(ua_flag, 1'b0)
    u_isgc_bus_master.stop();
    $display("test ten bit done");
    end_sim();
  end
endmodule : isgc_slave_tb_top
`default_nettype wire
